//--- verilog/flash_prog_pkg.sv
package flash_prog_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LOCK = 8'h04;

  // Control and status fields
  localparam int BIT_BUSY = 6;
  localparam int BIT_IRQ_EN = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Accepted command patterns in the low five control bits
  localparam logic [4:0] PAT_STORE = 5'h01;
  localparam logic [4:0] PAT_ERASE = 5'h03;
  localparam logic [4:0] PAT_WRITE = 5'h05;
  localparam logic [4:0] PAT_LOCK = 5'h09;
  localparam logic [4:0] PAT_REEN = 5'h11;

  // Lock bits: low bit of each pair gates writes, '0' means programmed
  localparam int LOCK_APP_LSB = 2;
  localparam int LOCK_BOOT_LSB = 4;
  localparam logic [1:0] LOCK_RST = 2'h3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int ARM_CYCLES = 4;
  localparam logic [1:0] ARM_LAST = 2'(ARM_CYCLES - 1);

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ARMED = 3'h2,
    ST_BUSY = 3'h4
  } state_e;

  typedef struct packed {
    logic reenable;
    logic lock_set;
    logic page_write;
    logic page_erase;
    logic enable;
  } cmd_s;

endpackage : flash_prog_pkg

//--- verilog/flash_self_program_control.sv
`timescale 1ns/100ps
// Overview of operation
// - Setting enable arms store instruction for four cycles; unarmed stores do nothing.
// - Enable plus one command bit makes next store do that special operation.
// - Enable alone: next store writes the 16-bit R_PAIR_I into buffer word at pointer, LSB ignored.
// - Enable clears when a store completes or four cycles pass unused.
// - Enable reads one while a page erase or write is running.
// - Only the five listed low-bit patterns are accepted; others have no effect.
// - Flash splits into application and boot sections by boot size fuses.
// - Stores fetched from the application section are disabled.
// - Stores fetched from the boot section may program anywhere in flash.
// - Programming a concurrent-read page keeps CPU running, fetching from stall section.
// - Programming a stall-section page stalls the CPU for the whole operation.
// - Boot section always lies inside the stall section.
// - Busy flag reads one while concurrent-read section is blocked.
// - Lock set 0 guards the application section, lock set 1 the boot section.
// - Page write command writes buffer to page at upper pointer bits.
// - Page erase command erases page at upper pointer bits, then auto-clears.
// - Re-enable while buffer is filling clears the whole buffer.
// - Ready interrupt when enabled and idle, never during EEPROM write or flash op.
module flash_self_program_control #(
  parameter int FLASH_WORDS = 8192,
  parameter int PAGE_WORDS = 64,
  parameter int BOOT_MIN_WORDS = 128,
  parameter int STALL_WORDS = 1024,
  parameter int AW = $clog2(FLASH_WORDS),
  parameter int PW = $clog2(PAGE_WORDS)
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SPM_STROBE_I,
  input wire logic [AW-1:0] FETCH_ADDR_I,
  input wire logic [15:0] Z_PTR_I,
  input wire logic [15:0] R_PAIR_I,
  input wire logic GLOBAL_IRQ_EN_I,
  input wire logic EE_WRITE_BUSY_I,
  input wire logic [1:0] BOOT_SIZE_I,
  input wire logic FLASH_DONE_I,
  input wire logic [PW-1:0] FLASH_RD_IDX_I,
  output logic [15:0] FLASH_RD_DATA_O,
  output logic FLASH_ERASE_O,
  output logic FLASH_WRITE_O,
  output logic [AW-PW-1:0] FLASH_PAGE_O,
  output logic CPU_STALL_O,
  output logic RWW_BUSY_O,
  output logic READY_IRQ_O
);

  // ************************************************************
  // Section map
  // ************************************************************
  localparam logic [AW:0] STALL_START = (AW+1)'(FLASH_WORDS - STALL_WORDS);

  flash_prog_pkg::state_e st_r, st_nxt;
  flash_prog_pkg::cmd_s cmd_r, cmd_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic irq_en_r, irq_en_nxt, busy_r, busy_nxt, stall_r, stall_nxt, fill_r, fill_nxt;
  logic erase_r, erase_nxt, write_r, write_nxt, irq_r, irq_nxt;
  logic [AW-PW-1:0] page_r, page_nxt;
  logic [1:0] lock_app_r, lock_app_nxt, lock_boot_r, lock_boot_nxt;
  logic [1:0] fuse_s1_r, fuse_s2_r;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [15:0] rd_data_r;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic buf_we, buf_clr;
  logic ctrl_wr, pat_ok, from_boot, tgt_boot, tgt_stall, tgt_locked, spm_go;
  logic [AW:0] boot_len, boot_start, tgt;
  logic [7:0] ctrl_rd;

  // Fuses are straps from outside the clock domain
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fuse_s1_r <= 2'h0;
      fuse_s2_r <= 2'h0;
    end else begin
      fuse_s1_r <= BOOT_SIZE_I;
      fuse_s2_r <= fuse_s1_r;
    end
  end

  // ************************************************************
  // Address classification
  // ************************************************************
  // Boot section grows downward from the top; largest size never passes the stall boundary
  assign boot_len = (AW+1)'(BOOT_MIN_WORDS) << (~fuse_s2_r);
  assign boot_start = (AW+1)'(FLASH_WORDS) - boot_len;
  assign from_boot = {1'b0, FETCH_ADDR_I} >= boot_start;
  assign tgt = {1'b0, Z_PTR_I[AW:1]};
  assign tgt_boot = tgt >= boot_start;
  assign tgt_stall = tgt >= STALL_START;
  assign tgt_locked = tgt_boot ? ~lock_boot_r[0] : ~lock_app_r[0];
  assign spm_go = (st_r == flash_prog_pkg::ST_ARMED) && SPM_STROBE_I && from_boot;

  // Control write decode; the accept pulse aligns with the APB completing edge
  assign ctrl_wr = PSEL_I && PENABLE_I && PWRITE_I && pready_r && (PADDR_I == flash_prog_pkg::ADDR_CTRL);
  assign pat_ok = PWDATA_I[4:0] inside {flash_prog_pkg::PAT_STORE, flash_prog_pkg::PAT_ERASE,
    flash_prog_pkg::PAT_WRITE, flash_prog_pkg::PAT_LOCK, flash_prog_pkg::PAT_REEN};
  assign ctrl_rd = {irq_en_r, busy_r, 1'b0, cmd_r};

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Commands are only taken when idle, so a running operation cannot be rearmed
  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    stall_nxt = stall_r;
    fill_nxt = fill_r;
    page_nxt = page_r;
    lock_app_nxt = lock_app_r;
    lock_boot_nxt = lock_boot_r;
    erase_nxt = 1'b0;
    write_nxt = 1'b0;
    buf_we = 1'b0;
    buf_clr = 1'b0;
    irq_en_nxt = ctrl_wr ? PWDATA_I[flash_prog_pkg::BIT_IRQ_EN] : irq_en_r;
    unique case (st_r)
      flash_prog_pkg::ST_IDLE: begin
        if (ctrl_wr && pat_ok) begin
          st_nxt = flash_prog_pkg::ST_ARMED;
          cmd_nxt = flash_prog_pkg::cmd_s'(PWDATA_I[4:0]);
          cnt_nxt = 2'h0;
        end
      end
      flash_prog_pkg::ST_ARMED: begin
        if (spm_go) begin
          st_nxt = flash_prog_pkg::ST_IDLE;
          cmd_nxt = '0;
          if (cmd_r.page_erase || cmd_r.page_write) begin
            if (!tgt_locked) begin
              st_nxt = flash_prog_pkg::ST_BUSY;
              cmd_nxt = cmd_r;
              erase_nxt = cmd_r.page_erase;
              write_nxt = cmd_r.page_write;
              page_nxt = Z_PTR_I[AW:PW+1];
              stall_nxt = tgt_stall;
              busy_nxt = 1'b1;
              fill_nxt = cmd_r.page_write ? 1'b0 : fill_r;
            end
          end else if (cmd_r.lock_set) begin
            lock_app_nxt = lock_app_r & R_PAIR_I[flash_prog_pkg::LOCK_APP_LSB +: 2];
            lock_boot_nxt = lock_boot_r & R_PAIR_I[flash_prog_pkg::LOCK_BOOT_LSB +: 2];
          end else if (cmd_r.reenable) begin
            busy_nxt = 1'b0;
            buf_clr = fill_r;
            fill_nxt = 1'b0;
          end else begin
            buf_we = 1'b1;
            fill_nxt = 1'b1;
          end
        end else if (cnt_r == flash_prog_pkg::ARM_LAST) begin
          st_nxt = flash_prog_pkg::ST_IDLE;
          cmd_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 2'h1;
        end
      end
      flash_prog_pkg::ST_BUSY: begin
        if (FLASH_DONE_I) begin
          st_nxt = flash_prog_pkg::ST_IDLE;
          cmd_nxt = '0;
          stall_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = flash_prog_pkg::ST_IDLE;
        cmd_nxt = '0;
      end
    endcase
    // Interrupt is quiet during EEPROM writes and any flash activity
    irq_nxt = irq_en_r && GLOBAL_IRQ_EN_I && (st_r == flash_prog_pkg::ST_IDLE) && !EE_WRITE_BUSY_I;
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_r <= flash_prog_pkg::ST_IDLE;
      cmd_r <= '0;
      cnt_r <= 2'h0;
      irq_en_r <= 1'b0;
      busy_r <= 1'b0;
      stall_r <= 1'b0;
      fill_r <= 1'b0;
      page_r <= '0;
      lock_app_r <= flash_prog_pkg::LOCK_RST;
      lock_boot_r <= flash_prog_pkg::LOCK_RST;
      erase_r <= 1'b0;
      write_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      cnt_r <= cnt_nxt;
      irq_en_r <= irq_en_nxt;
      busy_r <= busy_nxt;
      stall_r <= stall_nxt;
      fill_r <= fill_nxt;
      page_r <= page_nxt;
      lock_app_r <= lock_app_nxt;
      lock_boot_r <= lock_boot_nxt;
      erase_r <= erase_nxt;
      write_r <= write_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ************************************************************
  // Temporary page buffer
  // ************************************************************
  // One word per entry; pointer LSB is a byte select and is dropped
  for (genvar g = 0; g < PAGE_WORDS; g++) begin : g_buf
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        buf_mem[g] <= 16'h0000;
      end else if (buf_clr) begin
        buf_mem[g] <= 16'h0000;
      end else if (buf_we && (Z_PTR_I[PW:1] == PW'(g))) begin
        buf_mem[g] <= R_PAIR_I;
      end
    end
  end

  // Flash array reads the buffer during a page write
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= buf_mem[FLASH_RD_IDX_I];
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  // Zero wait state: ready and read data are prepared in the setup cycle
  always_comb begin
    pready_nxt = PSEL_I && !PENABLE_I;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (PSEL_I && !PENABLE_I) begin
      unique case (PADDR_I)
        flash_prog_pkg::ADDR_CTRL: prdata_nxt = {24'h00_0000, ctrl_rd};
        flash_prog_pkg::ADDR_LOCK: prdata_nxt = {28'h000_0000, lock_boot_r, lock_app_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign PRDATA_O = prdata_r;
  assign FLASH_RD_DATA_O = rd_data_r;
  assign FLASH_ERASE_O = erase_r;
  assign FLASH_WRITE_O = write_r;
  assign FLASH_PAGE_O = page_r;
  assign CPU_STALL_O = stall_r;
  assign RWW_BUSY_O = busy_r;
  assign READY_IRQ_O = irq_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_armed_unused;
    (st_r == flash_prog_pkg::ST_ARMED && !SPM_STROBE_I)[*4];
  endsequence

  sequence s_op_start;
    spm_go && (cmd_r.page_erase || cmd_r.page_write) && !tgt_locked;
  endsequence

  a_arm_expire: assert property ($rose(st_r == flash_prog_pkg::ST_ARMED) ##0 s_armed_unused
    |=> st_r == flash_prog_pkg::ST_IDLE && cmd_r == '0) else $error("Arm window not closed after four cycles");
  a_bad_pattern: assert property (ctrl_wr && !pat_ok && st_r == flash_prog_pkg::ST_IDLE
    |=> st_r == flash_prog_pkg::ST_IDLE && $stable(cmd_r)) else $error("Illegal pattern was accepted");
  a_app_store: assert property (st_r == flash_prog_pkg::ST_ARMED && SPM_STROBE_I && !from_boot
    |=> !FLASH_ERASE_O && !FLASH_WRITE_O && !buf_we) else $error("Store from application section acted");
  a_buf_store: assert property (spm_go && cmd_r == flash_prog_pkg::PAT_STORE
    |=> buf_mem[$past(Z_PTR_I[PW:1])] == $past(R_PAIR_I)) else $error("Buffer word not stored");
  a_busy_enable: assert property (st_r == flash_prog_pkg::ST_BUSY |-> ctrl_rd[0] && RWW_BUSY_O)
    else $error("Enable not held during flash operation");
  a_stall_start: assert property (s_op_start |=> CPU_STALL_O == $past(tgt_stall) && RWW_BUSY_O
    && (FLASH_ERASE_O || FLASH_WRITE_O)) else $error("Wrong stall or start on operation");
  a_stall_hold: assert property (CPU_STALL_O && !FLASH_DONE_I |=> CPU_STALL_O)
    else $error("Stall dropped before done");
  a_done_release: assert property (st_r == flash_prog_pkg::ST_BUSY && FLASH_DONE_I
    |=> !CPU_STALL_O && cmd_r == '0 && RWW_BUSY_O) else $error("Done did not release correctly");
  a_irq_quiet: assert property (st_r != flash_prog_pkg::ST_IDLE || EE_WRITE_BUSY_I |=> !READY_IRQ_O)
    else $error("Ready interrupt during activity");
  a_boot_inside: assert property (boot_start >= STALL_START)
    else $error("Boot section outside stall section");

endmodule : flash_self_program_control

//--- testbench/cpu_core_model.sv
`timescale 1ns/100ps
// ************************************************************
// CPU core issuing store instructions, plus flash array stand-in
// ************************************************************
module cpu_core_model #(
  parameter int AW = 13
) (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic start_i,
  input wire logic [7:0] lat_i,
  output logic strobe_o,
  output logic [AW-1:0] fetch_o,
  output logic [15:0] z_o,
  output logic [15:0] r_o,
  output logic done_o
);
  int cnt = 0;

  initial begin
    strobe_o = 1'b0;
    fetch_o = '0;
    z_o = 16'h0000;
    r_o = 16'h0000;
    done_o = 1'b0;
  end

  // Array reports done lat_i edges after a start, so runs can be prompt or slow
  always @(posedge clk_i) begin
    done_o <= (cnt == 1);
    if (start_i)
      cnt <= int'(lat_i);
    else if (cnt > 0)
      cnt <= cnt - 1;
  end

  // One store instruction; a halted core cannot issue, and it fetches from address f, boot or application
  task automatic issue(input logic [AW-1:0] f, input logic [15:0] z, input logic [15:0] r);
    @(posedge clk_i);
    while (stall_i === 1'b1) @(posedge clk_i);
    strobe_o <= 1'b1;
    fetch_o <= f;
    z_o <= z;
    r_o <= r;
    @(posedge clk_i);
    // Released operands do not keep their last value
    strobe_o <= 1'b0;
    fetch_o <= ~f;
    z_o <= ~z;
    r_o <= ~r;
  endtask : issue
endmodule : cpu_core_model

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int BOOT_FETCH = 8191;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, strobe, gie, ee, done;
  logic erase, write, stall, busy, irq;
  logic [7:0] paddr, lat;
  logic [31:0] pwdata, prdata, seed, rd;
  logic [12:0] fetch;
  logic [15:0] zp, rp, rd_data, d, w;
  logic [1:0] boot;
  logic [5:0] rd_idx;
  logic [6:0] page;
  logic err;
  logic [15:0] buf_m [64];
  logic [4:0] bad [4] = '{5'h07, 5'h19, 5'h02, 5'h1f};
  bit busy_m, irq_m;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  flash_self_program_control dut (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SPM_STROBE_I(strobe), .FETCH_ADDR_I(fetch), .Z_PTR_I(zp), .R_PAIR_I(rp),
    .GLOBAL_IRQ_EN_I(gie), .EE_WRITE_BUSY_I(ee), .BOOT_SIZE_I(boot), .FLASH_DONE_I(done),
    .FLASH_RD_IDX_I(rd_idx), .FLASH_RD_DATA_O(rd_data), .FLASH_ERASE_O(erase), .FLASH_WRITE_O(write),
    .FLASH_PAGE_O(page), .CPU_STALL_O(stall), .RWW_BUSY_O(busy), .READY_IRQ_O(irq));
  cpu_core_model #(.AW(13)) cpu (.clk_i(clk), .stall_i(stall), .start_i(erase | write), .lat_i(lat),
    .strobe_o(strobe), .fetch_o(fetch), .z_o(zp), .r_o(rp), .done_o(done));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] ctrl_exp(input bit en);
    return {24'h0, irq_m, busy_m, 5'h00, en};
  endfunction : ctrl_exp

  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk_r(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_r

  task automatic chk_s(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t signal %b expected %b", $time, got, exp);
    end
  endtask : chk_s

  // Zero-wait slave, but the master still waits for the answer; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= rnd();
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_r(rd, exp);
  endtask : rdchk

  task automatic rdbuf(input int idx);
    @(posedge clk);
    rd_idx <= 6'(idx);
    @(posedge clk);
    #1 d = rd_data;
  endtask : rdbuf

  task automatic store(input int f, input int idx, input int gap, input logic [15:0] v, input bit ok);
    apb(1'b1, flash_prog_pkg::ADDR_CTRL, 32'(flash_prog_pkg::PAT_STORE));
    repeat (gap) @(posedge clk);
    cpu.issue(13'(f), 16'(idx * 2 + 1), v);
    if (ok)
      buf_m[idx] = v;
    rdbuf(idx);
    chk_r(32'(d), 32'(buf_m[idx]));
    rdchk(flash_prog_pkg::ADDR_CTRL, ctrl_exp(0));
  endtask : store

  task automatic reen();
    apb(1'b1, flash_prog_pkg::ADDR_CTRL, 32'(flash_prog_pkg::PAT_REEN));
    cpu.issue(13'(BOOT_FETCH), 16'(rnd()), 16'(rnd()));
    busy_m = 0;
    rdchk(flash_prog_pkg::ADDR_CTRL, ctrl_exp(0));
  endtask : reen

  task automatic pageop(input logic [4:0] pat, input int pg, input int lt, input bit fires, input bit st);
    int n = 0;
    lat <= 8'(lt);
    apb(1'b1, flash_prog_pkg::ADDR_CTRL, 32'(pat));
    cpu.issue(13'(BOOT_FETCH), 16'(pg * 128), 16'(rnd()));
    #1 chk_s(pat == flash_prog_pkg::PAT_ERASE ? erase : write, fires);
    chk_s(stall, fires & st);
    busy_m = busy_m | fires;
    chk_s(busy, busy_m);
    if (!fires)
      return;
    chk_r(32'(page), 32'(pg));
    if (lt > 10) begin
      // Command bits stay set until the flash operation ends
      rdchk(flash_prog_pkg::ADDR_CTRL, ctrl_exp(1) | 32'(pat));
      chk_s(stall, st);
    end
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 100);
    #1 chk_s(stall, 1'b0);
    rdchk(flash_prog_pkg::ADDR_CTRL, ctrl_exp(0));
  endtask : pageop

  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hung handshake ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    seed = 32'd27228;
    {rst, psel, penable, pwrite, gie, ee} = 6'b100010;
    {paddr, pwdata, rd_idx, lat, boot} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(flash_prog_pkg::ADDR_CTRL, 32'h0);
    rdchk(flash_prog_pkg::ADDR_LOCK, 32'h0f);
    apb(1'b0, 8'h08, 32'h0);
    chk_s(err, 1'b1);
    chk_r(rd, 32'h0);
    for (int f = 0; f < 4; f++) begin
      boot <= 2'(f);
      repeat (3) @(posedge clk);
      store(8192 - (128 << (3 - f)), f + 1, 0, 16'(rnd()), 1);
      store(8191 - (128 << (3 - f)), f + 1, 0, 16'(rnd()), 0);
    end
    store(BOOT_FETCH, 1, 6, 16'(rnd()), 0);
    foreach (bad[i]) begin
      apb(1'b1, flash_prog_pkg::ADDR_CTRL, 32'(bad[i]));
      rdchk(flash_prog_pkg::ADDR_CTRL, ctrl_exp(0));
    end
    w = 16'(rnd());
    store(BOOT_FETCH, 7, 0, w, 1);
    reen();
    rdbuf(7);
    buf_m = '{default: 16'h0000};
    chk_r(32'(d), 32'(buf_m[7]));
    pageop(flash_prog_pkg::PAT_ERASE, 3, 30, 1, 0);
    reen();
    pageop(flash_prog_pkg::PAT_WRITE, 120, 30, 1, 1);
    reen();
    apb(1'b1, flash_prog_pkg::ADDR_CTRL, 32'(flash_prog_pkg::PAT_LOCK));
    cpu.issue(13'(BOOT_FETCH), 16'h0000, 16'hfff3);
    rdchk(flash_prog_pkg::ADDR_LOCK, 32'h0c);
    pageop(flash_prog_pkg::PAT_ERASE, 3, 3, 0, 0);
    pageop(flash_prog_pkg::PAT_ERASE, 126, 3, 1, 1);
    reen();
    apb(1'b1, flash_prog_pkg::ADDR_CTRL, 32'h80);
    irq_m = 1;
    repeat (2) @(posedge clk);
    #1 chk_s(irq, 1'b1);
    @(posedge clk);
    ee <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk_s(irq, 1'b0);
    @(posedge clk);
    ee <= 1'b0;
    apb(1'b1, flash_prog_pkg::ADDR_CTRL, 32'h81);
    @(posedge clk);
    #1 chk_s(irq, 1'b0);
    repeat (8) @(posedge clk);
    #1 chk_s(irq, 1'b1);
    rdchk(flash_prog_pkg::ADDR_CTRL, ctrl_exp(0));
    finish_test();
  end
endmodule : tb
